/* design/tccop_consts.vh */
// Register offsets, field positions and reset values of the capture block
`ifndef TCCOP_CONSTS_VH
`define TCCOP_CONSTS_VH

// Register offsets (byte registers on the plain port)
`define TCCOP_A_CTRL2     4'h0
`define TCCOP_A_CTRL1     4'h1
`define TCCOP_A_STATUS    4'h2
`define TCCOP_A_CAP1H     4'h3
`define TCCOP_A_CAP1L     4'h4
`define TCCOP_A_CMP1H     4'h5
`define TCCOP_A_CMP1L     4'h6
`define TCCOP_A_CNTH      4'h7
`define TCCOP_A_CNTL      4'h8
`define TCCOP_A_CAP2H     4'h9
`define TCCOP_A_CAP2L     4'hA
`define TCCOP_A_CMP2H     4'hB
`define TCCOP_A_CMP2L     4'hC

// Second control register fields
`define TCCOP_C2_PEN1     7
`define TCCOP_C2_PEN2     6
`define TCCOP_C2_PULSE    5
`define TCCOP_C2_PWM      4
`define TCCOP_C2_CKH      3
`define TCCOP_C2_CKL      2
`define TCCOP_C2_EDGE2    1

// First control register fields
`define TCCOP_C1_CIE      7
`define TCCOP_C1_OIE      6
`define TCCOP_C1_FORCE2   4
`define TCCOP_C1_FORCE1   3
`define TCCOP_C1_LVL2     2
`define TCCOP_C1_EDGE1    1
`define TCCOP_C1_LVL1     0

// Status register fields
`define TCCOP_S_CF1       7
`define TCCOP_S_OF1       6
`define TCCOP_S_CF2       4
`define TCCOP_S_OF2       3

// Timer clock select codes
`define TCCOP_CLK_DIV2    2'h0
`define TCCOP_CLK_DIV4    2'h1
`define TCCOP_CLK_DIV8    2'h2
`define TCCOP_CLK_EXT     2'h3

// Reset and load values
`define TCCOP_CMP_RST     16'h8000
`define TCCOP_CNT_LOAD    16'hFFFC
`define TCCOP_PULSE_CAP   16'hFFFD
`define TCCOP_CTRL_RST    8'h00

`endif

/* design/tccop_top.v */
// Capture, compare and one-pulse logic around a 16-bit up-counter
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "tccop_consts.vh"

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Active capture edge copies counter into capture value
// - Per-channel edge select bit picks rising/falling
// - Capture sets flag; interrupt if enabled and unmasked
// - Status read then low-byte access clears capture flag
// - High-byte read blocks capture until low read
// - Capture pins always watched, any selected edge counts
// - One-pulse or PWM: only capture channel 2 works
// - Compare each tick: flag, pin, interrupt on match
// - Compare values software-owned, reset to 8000h
// - Match drives programmed level; pin latch low in reset
// - Status read then low-byte access clears compare flag
// - Compare high write inhibits compare until low write
// - Low-byte write after status read clears compare flag
// - Pin disabled: no level, interrupt still possible
// - Flag and pin update while counter equals compare
// - Force bit copies level, no flag, not in modes
// - One-pulse select bit takes channel 1 pair
// - One-pulse trigger loads FFFCh, level2, flag, FFFDh
// - One-pulse compare 1 match drives level1
// - One-pulse: no compare flag 1, channel 2 no pin
// - PWM bit overrides one-pulse select
// - Pulse lasts compare value 1 plus four counts
// - Timer tick is clock/2, /4, /8 or external
module tccop_top (
    input  wire        REF_CLK,
    input  wire        RST_N,
    input  wire        CLK_EN,
    input  wire [3:0]  ADDR,
    input  wire [7:0]  WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [7:0]  RDATA,
    input  wire        CAP_PIN1,
    input  wire        CAP_PIN2,
    input  wire        EXT_TICK,
    input  wire        CPU_MASK,
    output reg         IRQ,
    output reg         CMP_PIN1,
    output reg         CMP_PIN2,
    output reg         CMP_OE1_N,
    output reg         CMP_OE2_N,
    output reg  [15:0] COUNT
);

    // Edge qualifier shared by both capture channels
    function edge_hit;
        input prev;
        input now;
        input rising;
        begin
            edge_hit = rising ? (~prev & now) : (prev & ~now);
        end
    endfunction

    // Register decode used by several processes
    function acc;
        input [3:0] a;
        input [3:0] target;
        input       strobe;
        begin
            acc = strobe && (a == target);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control and state registers
    reg  [7:0]  ctrl1;
    reg  [7:0]  ctrl2;
    reg  [2:0]  presc;
    reg  [15:0] cap1;
    reg  [15:0] cap2;
    reg  [15:0] cmp1;
    reg  [15:0] cmp2;
    reg         cap_flag1;
    reg         cap_flag2;
    reg         cmp_flag1;
    reg         cmp_flag2;
    reg         arm_cf1;
    reg         arm_cf2;
    reg         arm_of1;
    reg         arm_of2;
    reg         cap_lock1;
    reg         cap_lock2;
    reg         cmp_on1;
    reg         cmp_on2;
    reg         pin_prev1;
    reg         pin_prev2;

    wire        any_acc  = WR | RD;
    wire        pwm_mode = ctrl2[`TCCOP_C2_PWM];
    // PWM wins over one-pulse when both are selected
    wire        pulse_mode = ctrl2[`TCCOP_C2_PULSE] & ~pwm_mode;
    wire        sp_mode  = pwm_mode | ctrl2[`TCCOP_C2_PULSE];
    wire [1:0]  clk_sel  = ctrl2[`TCCOP_C2_CKH:`TCCOP_C2_CKL];
    wire        pen1     = ctrl2[`TCCOP_C2_PEN1];
    wire        pen2     = ctrl2[`TCCOP_C2_PEN2];
    wire        lvl1     = ctrl1[`TCCOP_C1_LVL1];
    wire        lvl2     = ctrl1[`TCCOP_C1_LVL2];

    ////////////////////////////////////////////////////////////////////////
    // Timer tick from prescaler or external edge pulse
    reg         tick;

    always @* begin
        case (clk_sel)
            `TCCOP_CLK_DIV2: tick = presc[0];
            `TCCOP_CLK_DIV4: tick = &presc[1:0];
            `TCCOP_CLK_DIV8: tick = &presc;
            `TCCOP_CLK_EXT:  tick = EXT_TICK;
            default:        tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Event decode
    // Pins are never gated off, so toggling them as outputs still counts
    wire edge1 = edge_hit(pin_prev1, CAP_PIN1,
                          ctrl1[`TCCOP_C1_EDGE1]);
    wire edge2 = edge_hit(pin_prev2, CAP_PIN2,
                          ctrl2[`TCCOP_C2_EDGE2]);

    // Channel 1 capture is unavailable in either special mode
    wire cap_ev1 = edge1 & ~sp_mode & ~cap_lock1;
    wire cap_ev2 = edge2 & ~cap_lock2;
    wire pulse_trig = edge1 & pulse_mode;
    wire pulse_ev1 = pulse_trig & ~cap_lock1;

    // Match holds while the counter equals the compare value
    wire match1 = cmp_on1 && (COUNT == cmp1);
    wire match2 = cmp_on2 && (COUNT == cmp2);

    // Flag sets; PWM and one-pulse own compare flag 1
    wire set_of1 = match1 & ~sp_mode;
    wire set_of2 = match2 & ~pwm_mode;
    wire set_cf1 = cap_ev1 | pulse_ev1;
    wire set_cf2 = cap_ev2;

    // Low byte accesses that complete a clearing sequence
    wire lo_cap1 = acc(ADDR, `TCCOP_A_CAP1L, any_acc);
    wire lo_cap2 = acc(ADDR, `TCCOP_A_CAP2L, any_acc);
    wire lo_cmp1 = acc(ADDR, `TCCOP_A_CMP1L, any_acc);
    wire lo_cmp2 = acc(ADDR, `TCCOP_A_CMP2L, any_acc);
    wire rd_stat = acc(ADDR, `TCCOP_A_STATUS, RD);
    wire wr_c1   = acc(ADDR, `TCCOP_A_CTRL1, WR);

    ////////////////////////////////////////////////////////////////////////
    // Counter and prescaler; one-pulse trigger restarts from FFFCh
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            presc <= 3'h0;
            COUNT <= `TCCOP_CNT_LOAD;
        end else if (CLK_EN) begin
            presc <= presc + 3'h1;
            if (pulse_trig) begin
                // Restart gives the extra four counts of pulse length
                COUNT <= `TCCOP_CNT_LOAD;
                presc <= 3'h0;
            end else if (tick) begin
                COUNT <= COUNT + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers written by software
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            ctrl1 <= `TCCOP_CTRL_RST;
            ctrl2 <= `TCCOP_CTRL_RST;
        end else if (CLK_EN) begin
            if (wr_c1) begin
                ctrl1 <= WDATA;
            end
            if (acc(ADDR, `TCCOP_A_CTRL2, WR)) begin
                ctrl2 <= WDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare values: only software changes them
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            cmp1    <= `TCCOP_CMP_RST;
            cmp2    <= `TCCOP_CMP_RST;
            cmp_on1 <= 1'b1;
            cmp_on2 <= 1'b1;
        end else if (CLK_EN) begin
            if (acc(ADDR, `TCCOP_A_CMP1H, WR)) begin
                cmp1[15:8] <= WDATA;
                cmp_on1    <= 1'b0;
            end
            if (acc(ADDR, `TCCOP_A_CMP1L, WR)) begin
                cmp1[7:0] <= WDATA;
                cmp_on1   <= 1'b1;
            end
            if (acc(ADDR, `TCCOP_A_CMP2H, WR)) begin
                cmp2[15:8] <= WDATA;
                cmp_on2    <= 1'b0;
            end
            if (acc(ADDR, `TCCOP_A_CMP2L, WR)) begin
                cmp2[7:0] <= WDATA;
                cmp_on2   <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture values and high-byte locks
    // Locking keeps the low byte coherent with the high byte just read
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            cap1      <= 16'h0000;
            cap2      <= 16'h0000;
            cap_lock1 <= 1'b0;
            cap_lock2 <= 1'b0;
            pin_prev1 <= 1'b0;
            pin_prev2 <= 1'b0;
        end else if (CLK_EN) begin
            pin_prev1 <= CAP_PIN1;
            pin_prev2 <= CAP_PIN2;
            if (pulse_ev1) begin
                cap1 <= `TCCOP_PULSE_CAP;
            end else if (cap_ev1) begin
                cap1 <= COUNT;
            end
            if (cap_ev2) begin
                cap2 <= COUNT;
            end
            if (acc(ADDR, `TCCOP_A_CAP1H, RD)) begin
                cap_lock1 <= 1'b1;
            end else if (acc(ADDR, `TCCOP_A_CAP1L, RD)) begin
                cap_lock1 <= 1'b0;
            end
            if (acc(ADDR, `TCCOP_A_CAP2H, RD)) begin
                cap_lock2 <= 1'b1;
            end else if (acc(ADDR, `TCCOP_A_CAP2L, RD)) begin
                cap_lock2 <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags with two-step clear; a new set beats the clear
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            cap_flag1 <= 1'b0;
            cap_flag2 <= 1'b0;
            cmp_flag1 <= 1'b0;
            cmp_flag2 <= 1'b0;
            arm_cf1   <= 1'b0;
            arm_cf2   <= 1'b0;
            arm_of1   <= 1'b0;
            arm_of2   <= 1'b0;
        end else if (CLK_EN) begin
            // Status read arms the clear of every flag now set
            if (rd_stat) begin
                arm_cf1 <= cap_flag1;
                arm_cf2 <= cap_flag2;
                arm_of1 <= cmp_flag1;
                arm_of2 <= cmp_flag2;
            end
            if (set_cf1) begin
                cap_flag1 <= 1'b1;
            end else if (lo_cap1 && arm_cf1) begin
                cap_flag1 <= 1'b0;
                arm_cf1   <= 1'b0;
            end
            if (set_cf2) begin
                cap_flag2 <= 1'b1;
            end else if (lo_cap2 && arm_cf2) begin
                cap_flag2 <= 1'b0;
                arm_cf2   <= 1'b0;
            end
            if (set_of1) begin
                cmp_flag1 <= 1'b1;
            end else if (lo_cmp1 && arm_of1) begin
                cmp_flag1 <= 1'b0;
                arm_of1   <= 1'b0;
            end
            if (set_of2) begin
                cmp_flag2 <= 1'b1;
            end else if (lo_cmp2 && arm_of2) begin
                cmp_flag2 <= 1'b0;
                arm_of2   <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare output pins; pin latches sit low through reset
    // Force acts only on the write cycle; the bits stay in ctrl1 but do nothing more
    wire force1 = wr_c1 & WDATA[`TCCOP_C1_FORCE1] & ~sp_mode;
    wire force2 = wr_c1 & WDATA[`TCCOP_C1_FORCE2] & ~sp_mode;

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            CMP_PIN1  <= 1'b0;
            CMP_PIN2  <= 1'b0;
            CMP_OE1_N <= 1'b1;
            CMP_OE2_N <= 1'b1;
        end else if (CLK_EN) begin
            // Disabled pin stays general I/O and sees no level
            CMP_OE1_N <= ~pen1;
            CMP_OE2_N <= ~(pen2 & ~sp_mode);
            if (pen1) begin
                if (pulse_trig) begin
                    CMP_PIN1 <= lvl2;
                end else if (pulse_mode && match1) begin
                    // Equal levels give a constant output
                    CMP_PIN1 <= lvl1;
                end else if (~sp_mode && match1) begin
                    CMP_PIN1 <= lvl1;
                end else if (force1) begin
                    CMP_PIN1 <= WDATA[`TCCOP_C1_LVL1];
                end
            end
            if (pen2 && ~sp_mode) begin
                if (match2) begin
                    CMP_PIN2 <= lvl2;
                end else if (force2) begin
                    CMP_PIN2 <= WDATA[`TCCOP_C1_LVL2];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request; pending flags wait for enable and mask
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else if (CLK_EN) begin
            IRQ <= ~CPU_MASK &
                   ((ctrl1[`TCCOP_C1_CIE] & (cap_flag1 | cap_flag2)) |
                    (ctrl1[`TCCOP_C1_OIE] &
                     (cmp_flag1 | cmp_flag2)));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid in the cycle after the read strobe only
    reg [7:0] rd_mux;

    always @* begin
        rd_mux = 8'h00;
        case (ADDR)
            `TCCOP_A_CTRL2:  rd_mux = ctrl2;
            `TCCOP_A_CTRL1:  rd_mux = ctrl1;
            `TCCOP_A_STATUS: rd_mux = {cap_flag1, cmp_flag1, 1'b0,
                                       cap_flag2, cmp_flag2, 3'h0};
            `TCCOP_A_CAP1H:  rd_mux = cap1[15:8];
            `TCCOP_A_CAP1L:  rd_mux = cap1[7:0];
            `TCCOP_A_CMP1H:  rd_mux = cmp1[15:8];
            `TCCOP_A_CMP1L:  rd_mux = cmp1[7:0];
            `TCCOP_A_CNTH:   rd_mux = COUNT[15:8];
            `TCCOP_A_CNTL:   rd_mux = COUNT[7:0];
            `TCCOP_A_CAP2H:  rd_mux = cap2[15:8];
            `TCCOP_A_CAP2L:  rd_mux = cap2[7:0];
            `TCCOP_A_CMP2H:  rd_mux = cmp2[15:8];
            `TCCOP_A_CMP2L:  rd_mux = cmp2[7:0];
            default:         rd_mux = 8'h00;
        endcase
    end

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else if (CLK_EN) begin
            RDATA <= RD ? rd_mux : 8'h00;
        end
    end

endmodule

/* sim/tccop_chk.sv */
// Port-level assertions for the capture/compare block
`timescale 1ns/1ps
module tccop_chk (
    input wire        REF_CLK,
    input wire        RST_N,
    input wire        CLK_EN,
    input wire [3:0]  ADDR,
    input wire [7:0]  WDATA,
    input wire        WR,
    input wire        RD,
    input wire [7:0]  RDATA,
    input wire        CPU_MASK,
    input wire        IRQ,
    input wire        CMP_PIN1,
    input wire        CMP_OE1_N,
    input wire        CMP_OE2_N,
    input wire [15:0] COUNT
);
    reg  [7:0]  c1;
    reg  [7:0]  c2;
    reg  [15:0] cmp1;
    reg         inh;
    wire        norm = !c2[5] && !c2[4];
    wire        c1_wr = WR && ADDR == 4'h1;

    ////////////////////////////////////////////////////////////
    // Shadow of control and compare 1, snooped from the bus
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            c1 <= 8'h00;
            c2 <= 8'h00;
            cmp1 <= 16'h8000;
            inh <= 1'h0;
        end else if (CLK_EN && WR) begin
            if (ADDR == 4'h0) c2 <= WDATA;
            if (ADDR == 4'h1) c1 <= WDATA;
            if (ADDR == 4'h5) cmp1[15:8] <= WDATA;
            if (ADDR == 4'h6) cmp1[7:0] <= WDATA;
            if (ADDR == 4'h5) inh <= 1'h1;
            if (ADDR == 4'h6) inh <= 1'h0;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_match;
        CLK_EN && norm && c2[7] && !inh && COUNT == cmp1 && !c1_wr;
    endsequence
    sequence s_force;
        CLK_EN && c1_wr && WDATA[3] && norm && c2[7] &&
            !(COUNT == cmp1 && !inh);
    endsequence

    property p_rst;
        disable iff (1'b0) !RST_N && CLK_EN |=> COUNT == 16'hFFFC
            && !CMP_PIN1 && CMP_OE1_N && !IRQ;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_rd_idle;
        CLK_EN && !RD |=> RDATA == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
    property p_match;
        s_match |=> CMP_PIN1 == $past(c1[0]);
    endproperty
    a_match: assert property (p_match) else $error("no match level");
    property p_force;
        s_force |=> CMP_PIN1 == $past(WDATA[0]);
    endproperty
    a_force: assert property (p_force) else $error("force failed");
    property p_inh;
        CLK_EN && inh && norm && !c1_wr |=> $stable(CMP_PIN1);
    endproperty
    a_inh: assert property (p_inh) else $error("compare not held");
    property p_oe2;
        (c2[5] || c2[4]) && $past(c2[5] || c2[4]) |-> CMP_OE2_N;
    endproperty
    a_oe2: assert property (p_oe2) else $error("pin 2 driven");
    property p_gpio;
        !c2[7] && !$past(c2[7]) |-> CMP_OE1_N;
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin 1 driven");
    property p_mask;
        CLK_EN && CPU_MASK |=> !IRQ;
    endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    property p_ien;
        IRQ |-> c1[7:6] != 2'h0 || $past(c1[7:6]) != 2'h0;
    endproperty
    a_ien: assert property (p_ien) else $error("irq not enabled");
endmodule

bind tccop_top tccop_chk tccop_chk_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .CLK_EN(CLK_EN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CPU_MASK(CPU_MASK), .IRQ(IRQ), .CMP_PIN1(CMP_PIN1),
    .CMP_OE1_N(CMP_OE1_N), .CMP_OE2_N(CMP_OE2_N), .COUNT(COUNT));

/* sim/tccop_pins.sv */
// Far-side model: capture input pins and external timer tick source
`timescale 1ns/1ps
module tccop_pins (
    input  wire  clk,
    output logic cap1,
    output logic cap2,
    output logic ext_tick
);
    logic       ext_on = 1'h0;
    logic [1:0] ph = 2'h0;

    initial begin
        cap1 = 1'h0;
        cap2 = 1'h0;
        ext_tick = 1'h0;
    end

    // One tick every fourth core cycle, half the rate of the divide-by-2 prescaler
    always @(posedge clk) begin
        ph <= ph + 2'h1;
        ext_tick <= ext_on && ph == 2'h3;
    end

    // Pins move just after an edge and then hold until the next call
    task drive(input int ch, input logic x);
        @(posedge clk);
        if (ch == 1) cap1 <= x;
        else cap2 <= x;
    endtask
endmodule

/* sim/tccop_top_test.sv */
// Self-checking bench for the capture/compare/one-pulse block
`timescale 1ns/1ps
module tccop_top_test;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        clk_en = 1'h1;
    logic        wr = 1'h0;
    logic        rd = 1'h0;
    logic        mask = 1'h1;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  d;
    logic [15:0] c0;
    logic [15:0] v;
    wire  [7:0]  rdata;
    wire  [15:0] count;
    wire         cap1, cap2, tick, irq, p1, p2, oe1, oe2;
    int          failures = 0;
    int          n_checks = 0;
    int          k;

    initial forever #2.5 clk = ~clk;

    tccop_top tccop_top_i (.REF_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CAP_PIN1(cap1), .CAP_PIN2(cap2), .EXT_TICK(tick),
        .CPU_MASK(mask), .IRQ(irq), .CMP_PIN1(p1), .CMP_PIN2(p2),
        .CMP_OE1_N(oe1), .CMP_OE2_N(oe2), .COUNT(count));
    tccop_pins tccop_pins_i (.clk(clk), .cap1(cap1), .cap2(cap2),
        .ext_tick(tick));

    ////////////////////////////////////////////////////////////
    // Bus cycles and compare helper
    task chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    // Read data stand one cycle only, so sample mid-cycle
    task rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        d = rdata;
    endtask
    task rd16(input logic [3:0] a);
        rd_reg(a);
        v[15:8] = d;
        rd_reg(a + 4'h1);
        v[7:0] = d;
    endtask
    task waitc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task pulse1;
        tccop_pins_i.drive(1, 1'h0);
        tccop_pins_i.drive(1, 1'h1);
    endtask

    ////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset;
        rd16(4'h5); chk(v, 16'h8000);
        rd16(4'hB); chk(v, 16'h8000);
        wr_reg(4'h5, 8'h12); wr_reg(4'h6, 8'h34);
        rd16(4'h5); chk(v, 16'h1234);
        rd_reg(4'hD); chk(d, 16'h0);
    endtask
    task t_capture;
        wr_reg(4'h1, 8'h02);
        wr_reg(4'h0, 8'h00);
        tccop_pins_i.drive(2, 1'h1);
        waitc(4); rd_reg(4'h2); chk(d[4], 16'h0);
        @(negedge clk) c0 = count;
        tccop_pins_i.drive(1, 1'h1); tccop_pins_i.drive(2, 1'h0);
        waitc(4); rd_reg(4'h2); chk({d[7], d[4]}, 16'h3);
        rd16(4'h3); chk(v - c0 < 16'h4, 16'h1);
        c0 = v;
        rd_reg(4'hA); rd_reg(4'h2); chk({d[7], d[4]}, 16'h0);
        tccop_pins_i.drive(2, 1'h1); tccop_pins_i.drive(2, 1'h0);
        waitc(4); rd_reg(4'hA); rd_reg(4'h2); chk(d[4], 16'h1);
        rd_reg(4'hA); rd_reg(4'h2); chk(d[4], 16'h0);
        rd_reg(4'h3); pulse1; waitc(4);
        rd_reg(4'h2); chk(d[7], 16'h0);
        rd_reg(4'h4); rd_reg(4'h2); chk(d[7], 16'h0);
        rd16(4'h3); chk(v, c0);
        wr_reg(4'h1, 8'h82); pulse1; waitc(4); chk(irq, 16'h0);
        @(posedge clk) mask <= 1'h0;
        waitc(3); chk(irq, 16'h1);
        rd_reg(4'h2); rd_reg(4'h4); waitc(2); chk(irq, 16'h0);
    endtask
    task t_compare;
        // Level 2 set so a wrongly driven disabled pin 2 would show
        wr_reg(4'h0, 8'h80); wr_reg(4'h1, 8'h05);
        v = count + 16'h0028;
        wr_reg(4'h5, v[15:8]); wr_reg(4'h6, v[7:0]);
        wr_reg(4'hB, v[15:8]); wr_reg(4'hC, v[7:0]);
        for (k = 0; k < 200 && p1 !== 1'h1; k++) @(negedge clk);
        chk({p1, oe1, p2}, 16'h4);
        waitc(4); rd_reg(4'h2); chk({d[6], d[3], oe2}, 16'h7);
        wr_reg(4'h5, 8'h00); rd_reg(4'h2); wr_reg(4'h6, 8'h00);
        rd_reg(4'h2); chk(d[6], 16'h0);
        rd_reg(4'hC); rd_reg(4'h2); chk(d[3], 16'h0);
        wr_reg(4'h1, 8'h08); waitc(2); chk(p1, 16'h0);
        rd_reg(4'h2); chk(d[6], 16'h0);
        wr_reg(4'h0, 8'hC0); wr_reg(4'h1, 8'h14); waitc(2);
        chk({p2, oe2}, 16'h2);
        rd_reg(4'h2); chk(d[3], 16'h0);
    endtask
    task t_pulse;
        wr_reg(4'h6, 8'h10); wr_reg(4'h1, 8'h06); wr_reg(4'h0, 8'hA0);
        pulse1;
        for (k = 0; k < 20 && p1 !== 1'h1; k++) @(negedge clk);
        for (k = 0; k < 100 && p1 === 1'h1; k++) @(negedge clk);
        chk(k >= 40 && k <= 44, 16'h1);
        rd_reg(4'h2); chk({d[7], d[6]}, 16'h2);
        rd16(4'h3); chk(v, 16'hFFFD);
        wr_reg(4'h1, 8'h07); pulse1; waitc(3);
        c0 = 16'h0;
        for (k = 0; k < 60; k++) begin
            @(negedge clk);
            if (p1 !== 1'h1) c0++;
        end
        chk(c0, 16'h0);
        wr_reg(4'h0, 8'hB0); pulse1; waitc(4);
        chk(count[15], 16'h0);
        wr_reg(4'h0, 8'h00);
    endtask
    task t_clock;
        // A low clock enable must hold the counter still
        @(posedge clk) clk_en <= 1'h0;
        @(negedge clk) c0 = count;
        waitc(20); chk(count, c0);
        @(posedge clk) clk_en <= 1'h1;
        for (k = 0; k < 4; k++) begin
            wr_reg(4'h0, 8'(k << 2));
            tccop_pins_i.ext_on <= k == 3;
            @(negedge clk) c0 = count;
            waitc(80);
            v = count - c0 - (k == 3 ? 16'h14 : 16'h50 >> (k + 1));
            chk(v + 16'h1 <= 16'h2, 16'h1);
        end
    endtask

    task close_out;
        if (failures == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        t_reset;
        t_capture;
        t_compare;
        t_pulse;
        t_clock;
        close_out;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out;
    end
endmodule
